// File: rtl/ufc_uart.sv
// Functional notes
// - Full duplex, four-deep queue each direction.
// - Assert request-to-send when receive queue nears full.
// - Clear-to-send asserted and enabled halts transmission.
// - Base clock is system clock over divider+1.
// - Bit time is period count+1 base cycles.
// - First control holds DMA and interrupt enables.
// - Clear-to-send inversion and enable in second control.
// - Parity enable and even/odd select.
// - Stop field picks one, one and a half, two.
// - Line inversion flips receive and transmit levels.
// - Loopback ties transmitter output to receiver input.
// - Flow register: threshold, polarity, force, enable.
// - Interrupt thresholds for receive and transmit counts.
// - Receive idle timeout ends a DMA transaction.
// - Scale field multiplies timeout by one to four.
// - Count register reports both queue fills.
// - Status reports counts, interrupt, error; clears queues.
// - Data window writes transmit, reads receive.
// - Data window storage has no reset value.
module ufc_uart
  import ufc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_pin,
  input wire logic cts_pin,
  output logic tx_pin,
  output logic rts_pin,
  output logic irq,
  output logic rx_dma_req,
  output logic tx_dma_req,
  output logic rx_idle_done
);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  logic [7:0] div_lo_reg, div_hi_reg, ctrl0_reg, ctrl1_reg;
  logic [7:0] rts_ctl_reg, trig_reg, tout_base_reg;
  logic [1:0] tout_scale_reg;
  logic wr_pend_reg, rd_wait_reg, hready_reg, rx_err_reg;
  logic [7:0] wr_idx_reg, rd_idx_reg, idx, rd_val;
  logic [31:0] hrdata_reg;
  logic [1:0] rx_sync_reg, cts_sync_reg;
  logic tx_pin_reg, rts_pin_reg, irq_reg;
  logic rx_dma_reg, tx_dma_reg, idle_done_reg;
  logic addr_ok, in_window, wr_go, clr_rx, clr_tx, rx_pop, tx_pop;
  logic rx_in, cts_hold, base_tick, rx_busy;
  logic [14:0] div_cnt_reg;
  logic [3:0] bwpc;
  logic [4:0] bit_ticks;
  logic [5:0] stop_m1;
  logic [2:0] rx_cnt, tx_cnt;
  logic [7:0] rx_dout, tx_dout;
  ufc_tx_state_e tx_st_reg;
  ufc_rx_state_e rx_st_reg;
  logic [5:0] tx_cnt_reg;
  logic [3:0] rx_cnt_reg;
  logic [2:0] tx_bit_reg, rx_bit_reg;
  logic [7:0] tx_sh_reg, rx_sh_reg;
  logic tx_line_reg, tx_par_reg, rx_perr_reg, rx_push_reg, rx_bad_reg;
  logic [9:0] tout_cnt_reg, tout_mul, tout_limit;
  logic tout_armed_reg;

  // ****************************************************************
  // Bus slave.
  // ****************************************************************
  assign idx = (haddr[31:10] == 22'h0) ? haddr[9:2] : UFC_IDX_NONE;
  assign addr_ok = hsel && htrans[1] && hready;
  assign in_window = (rd_idx_reg >= UFC_IDX_DATA0) &&
    (rd_idx_reg <= UFC_IDX_DATA3);
  assign wr_go = ce && wr_pend_reg;
  assign clr_rx = wr_go && (wr_idx_reg == UFC_IDX_STATUS) &&
    hwdata[UFC_STS_CLR_RX];
  assign clr_tx = wr_go && (wr_idx_reg == UFC_IDX_STATUS) &&
    hwdata[UFC_STS_CLR_TX];
  assign rx_pop = rd_wait_reg && in_window;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= UFC_IDX_NONE;
      rd_wait_reg <= 1'b0;
      rd_idx_reg <= UFC_IDX_NONE;
      hready_reg <= 1'b1;
      hrdata_reg <= 32'h0000_0000;
    end
    else if (ce)
    begin
      wr_pend_reg <= addr_ok && hwrite;
      wr_idx_reg <= idx;
      if (addr_ok && !hwrite)
      begin
        rd_wait_reg <= 1'b1;
        rd_idx_reg <= idx;
        hready_reg <= 1'b0;
      end
      else if (rd_wait_reg)
      begin
        rd_wait_reg <= 1'b0;
        hready_reg <= 1'b1;
        hrdata_reg <= {24'h00_0000, rd_val};
      end
    end
  end

  always_comb
  begin
    unique case (rd_idx_reg)
      UFC_IDX_DATA0, UFC_IDX_DATA1, UFC_IDX_DATA2, UFC_IDX_DATA3:
        rd_val = rx_dout;
      UFC_IDX_DIV_LO: rd_val = div_lo_reg;
      UFC_IDX_DIV_HI: rd_val = div_hi_reg;
      UFC_IDX_CTRL0: rd_val = ctrl0_reg;
      UFC_IDX_CTRL1: rd_val = ctrl1_reg;
      UFC_IDX_RTS: rd_val = rts_ctl_reg;
      UFC_IDX_TRIG: rd_val = trig_reg;
      UFC_IDX_TOUT_BASE: rd_val = tout_base_reg;
      UFC_IDX_TOUT_SCALE: rd_val = {6'h00, tout_scale_reg};
      UFC_IDX_COUNT: rd_val = {1'b0, tx_cnt, 1'b0, rx_cnt};
      UFC_IDX_STATUS:
        rd_val = {rx_err_reg, tx_cnt, irq_reg, rx_cnt};
      default: rd_val = 8'h00;
    endcase
  end

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      div_lo_reg <= UFC_RST_DIV_LO;
      div_hi_reg <= UFC_RST_DIV_HI;
      ctrl0_reg <= UFC_RST_CTRL0;
      ctrl1_reg <= UFC_RST_CTRL1;
      rts_ctl_reg <= UFC_RST_RTS;
      trig_reg <= UFC_RST_TRIG;
      tout_base_reg <= UFC_RST_TOUT_BASE;
      tout_scale_reg <= UFC_RST_TOUT_SCALE;
    end
    else if (wr_go)
    begin
      case (wr_idx_reg)
        UFC_IDX_DIV_LO: div_lo_reg <= hwdata[7:0];
        UFC_IDX_DIV_HI: div_hi_reg <= hwdata[7:0];
        UFC_IDX_CTRL0: ctrl0_reg <= hwdata[7:0];
        UFC_IDX_CTRL1: ctrl1_reg <= hwdata[7:0];
        UFC_IDX_RTS: rts_ctl_reg <= hwdata[7:0];
        UFC_IDX_TRIG: trig_reg <= hwdata[7:0];
        UFC_IDX_TOUT_BASE: tout_base_reg <= hwdata[7:0];
        UFC_IDX_TOUT_SCALE: tout_scale_reg <= hwdata[1:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Queues.
  // ****************************************************************
  ufc_queue u_rx_queue (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .clr(clr_rx),
    .push(rx_push_reg),
    .din(rx_sh_reg),
    .pop(rx_pop),
    .dout(rx_dout),
    .count(rx_cnt)
  );

  ufc_queue u_tx_queue (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .clr(clr_tx),
    .push(wr_go && (wr_idx_reg >= UFC_IDX_DATA0) &&
      (wr_idx_reg <= UFC_IDX_DATA3)),
    .din(hwdata[7:0]),
    .pop(tx_pop),
    .dout(tx_dout),
    .count(tx_cnt)
  );

  // ****************************************************************
  // Pin synchronisers and line options.
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_sync_reg <= 2'h3;
      cts_sync_reg <= 2'h0;
    end
    else if (ce)
    begin
      rx_sync_reg <= {rx_sync_reg[0], rx_pin};
      cts_sync_reg <= {cts_sync_reg[0], cts_pin};
    end
  end

  assign rx_in = ctrl1_reg[UFC_C1_LOOP] ? tx_line_reg :
    (rx_sync_reg[1] ^ ctrl1_reg[UFC_C1_LINE_INV]);
  assign cts_hold = ctrl1_reg[UFC_C1_CTS_EN] &&
    (cts_sync_reg[1] ^ ctrl1_reg[UFC_C1_CTS_INV]);

  // ****************************************************************
  // Base clock and bit timing.
  // ****************************************************************
  assign base_tick = !div_hi_reg[UFC_DIV_EN] ||
    (div_cnt_reg == {div_hi_reg[6:0], div_lo_reg});
  assign bwpc = ctrl0_reg[3:0];
  assign bit_ticks = {1'b0, bwpc} + 5'h01;

  always_comb
  begin
    if (ctrl1_reg[UFC_C1_STOP_HI])
    begin
      stop_m1 = {bit_ticks, 1'b0} - 6'h01;
    end
    else if (ctrl1_reg[UFC_C1_STOP_LO])
    begin
      stop_m1 = {1'b0, bit_ticks} + {2'h0, bit_ticks[4:1]} - 6'h01;
    end
    else
    begin
      stop_m1 = {1'b0, bit_ticks} - 6'h01;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      div_cnt_reg <= 15'h0000;
    end
    else if (ce)
    begin
      div_cnt_reg <= base_tick ? 15'h0000 : div_cnt_reg + 15'h0001;
    end
  end

  // ****************************************************************
  // Transmitter.
  // ****************************************************************
  assign tx_pop = ce && base_tick && (tx_st_reg == TX_START) &&
    (tx_cnt_reg == {2'h0, bwpc});

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_st_reg <= TX_IDLE;
      tx_cnt_reg <= 6'h00;
      tx_bit_reg <= 3'h0;
      tx_sh_reg <= 8'h00;
      tx_line_reg <= 1'b1;
      tx_par_reg <= 1'b0;
    end
    else if (ce && base_tick)
    begin
      tx_cnt_reg <= tx_cnt_reg + 6'h01;
      unique case (tx_st_reg)
        TX_IDLE:
        begin
          tx_cnt_reg <= 6'h00;
          if (tx_cnt != 3'h0 && !cts_hold)
          begin
            tx_st_reg <= TX_START;
            tx_line_reg <= 1'b0;
          end
        end
        TX_START:
          if (tx_cnt_reg == {2'h0, bwpc})
          begin
            tx_sh_reg <= tx_dout;
            tx_line_reg <= tx_dout[0];
            tx_par_reg <= (^tx_dout) ^ ctrl1_reg[UFC_C1_PAR_ODD];
            tx_bit_reg <= 3'h0;
            tx_cnt_reg <= 6'h00;
            tx_st_reg <= TX_DATA;
          end
        TX_DATA:
          if (tx_cnt_reg == {2'h0, bwpc})
          begin
            tx_cnt_reg <= 6'h00;
            tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
            tx_bit_reg <= tx_bit_reg + 3'h1;
            if (tx_bit_reg != 3'h7)
            begin
              tx_line_reg <= tx_sh_reg[1];
            end
            else if (ctrl1_reg[UFC_C1_PAR_EN])
            begin
              tx_line_reg <= tx_par_reg;
              tx_st_reg <= TX_PAR;
            end
            else
            begin
              tx_line_reg <= 1'b1;
              tx_st_reg <= TX_STOP;
            end
          end
        TX_PAR:
          if (tx_cnt_reg == {2'h0, bwpc})
          begin
            tx_cnt_reg <= 6'h00;
            tx_line_reg <= 1'b1;
            tx_st_reg <= TX_STOP;
          end
        TX_STOP:
          if (tx_cnt_reg == stop_m1)
          begin
            tx_cnt_reg <= 6'h00;
            tx_st_reg <= TX_IDLE;
          end
      endcase
    end
  end

  // ****************************************************************
  // Receiver.
  // ****************************************************************
  assign rx_busy = rx_st_reg != RX_IDLE;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_st_reg <= RX_IDLE;
      rx_cnt_reg <= 4'h0;
      rx_bit_reg <= 3'h0;
      rx_sh_reg <= 8'h00;
      rx_perr_reg <= 1'b0;
      rx_push_reg <= 1'b0;
      rx_bad_reg <= 1'b0;
    end
    else if (ce)
    begin
      rx_push_reg <= 1'b0;
      rx_bad_reg <= 1'b0;
      if (base_tick)
      begin
        rx_cnt_reg <= rx_cnt_reg + 4'h1;
        unique case (rx_st_reg)
          RX_IDLE:
          begin
            rx_cnt_reg <= 4'h0;
            rx_perr_reg <= 1'b0;
            if (!rx_in)
            begin
              rx_st_reg <= RX_START;
            end
          end
          RX_START:
            if (rx_cnt_reg == {1'b0, bwpc[3:1]})
            begin
              rx_cnt_reg <= 4'h0;
              rx_bit_reg <= 3'h0;
              rx_st_reg <= rx_in ? RX_IDLE : RX_DATA;
            end
          RX_DATA:
            if (rx_cnt_reg == bwpc)
            begin
              rx_cnt_reg <= 4'h0;
              rx_sh_reg <= {rx_in, rx_sh_reg[7:1]};
              rx_bit_reg <= rx_bit_reg + 3'h1;
              if (rx_bit_reg == 3'h7)
              begin
                rx_st_reg <= ctrl1_reg[UFC_C1_PAR_EN] ? RX_PAR : RX_STOP;
              end
            end
          RX_PAR:
            if (rx_cnt_reg == bwpc)
            begin
              rx_cnt_reg <= 4'h0;
              rx_perr_reg <= rx_in !=
                ((^rx_sh_reg) ^ ctrl1_reg[UFC_C1_PAR_ODD]);
              rx_st_reg <= RX_STOP;
            end
          RX_STOP:
            if (rx_cnt_reg == bwpc)
            begin
              rx_cnt_reg <= 4'h0;
              rx_push_reg <= 1'b1;
              rx_bad_reg <= !rx_in || rx_perr_reg ||
                (rx_cnt == UFC_DEPTH);
              rx_st_reg <= RX_IDLE;
            end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_err_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (rx_bad_reg)
      begin
        rx_err_reg <= 1'b1;
      end
      else if (clr_rx)
      begin
        rx_err_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Receive idle timeout.
  // ****************************************************************
  assign tout_mul = {8'h00, tout_scale_reg} + 10'h001;
  assign tout_limit = tout_mul * {2'h0, tout_base_reg};

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tout_cnt_reg <= 10'h000;
      tout_armed_reg <= 1'b0;
      idle_done_reg <= 1'b0;
    end
    else if (ce)
    begin
      idle_done_reg <= 1'b0;
      if (rx_push_reg)
      begin
        tout_cnt_reg <= 10'h000;
        tout_armed_reg <= 1'b1;
      end
      else if (rx_busy)
      begin
        tout_cnt_reg <= 10'h000;
      end
      else if (tout_armed_reg && base_tick)
      begin
        tout_cnt_reg <= tout_cnt_reg + 10'h001;
        if (tout_cnt_reg + 10'h001 >= tout_limit)
        begin
          tout_armed_reg <= 1'b0;
          idle_done_reg <= ctrl0_reg[UFC_C0_RX_DMA];
        end
      end
    end
  end

  // ****************************************************************
  // Output flops: line, flow control, interrupt, DMA requests.
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_pin_reg <= 1'b1;
      rts_pin_reg <= 1'b0;
      irq_reg <= 1'b0;
      rx_dma_reg <= 1'b0;
      tx_dma_reg <= 1'b0;
    end
    else if (ce)
    begin
      tx_pin_reg <= tx_line_reg ^ ctrl1_reg[UFC_C1_LINE_INV];
      if (rts_ctl_reg[UFC_RTS_MAN_EN])
      begin
        rts_pin_reg <= rts_ctl_reg[UFC_RTS_MAN_VAL];
      end
      else if (rts_ctl_reg[UFC_RTS_EN] &&
        ({1'b0, rx_cnt} >= rts_ctl_reg[3:0]))
      begin
        rts_pin_reg <= rts_ctl_reg[UFC_RTS_POL];
      end
      else
      begin
        rts_pin_reg <= !rts_ctl_reg[UFC_RTS_POL];
      end
      irq_reg <= (ctrl0_reg[UFC_C0_RX_INT] &&
        ({1'b0, rx_cnt} >= trig_reg[3:0])) ||
        (ctrl0_reg[UFC_C0_TX_INT] &&
        ({1'b0, tx_cnt} <= trig_reg[7:4]));
      rx_dma_reg <= ctrl0_reg[UFC_C0_RX_DMA] && (rx_cnt != 3'h0);
      tx_dma_reg <= ctrl0_reg[UFC_C0_TX_DMA] && (tx_cnt != UFC_DEPTH);
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hready_reg;
  assign hresp = 1'b0;
  assign tx_pin = tx_pin_reg;
  assign rts_pin = rts_pin_reg;
  assign irq = irq_reg;
  assign rx_dma_req = rx_dma_reg;
  assign tx_dma_req = tx_dma_reg;
  assign rx_idle_done = idle_done_reg;

endmodule : ufc_uart

// File: rtl/ufc_pkg.sv
package ufc_pkg;

  // ****************************************************************
  // Register indices, byte address is four times the index.
  // ****************************************************************
  localparam logic [7:0] UFC_IDX_DATA0 = 8'h90;
  localparam logic [7:0] UFC_IDX_DATA1 = 8'h91;
  localparam logic [7:0] UFC_IDX_DATA2 = 8'h92;
  localparam logic [7:0] UFC_IDX_DATA3 = 8'h93;
  localparam logic [7:0] UFC_IDX_DIV_LO = 8'h94;
  localparam logic [7:0] UFC_IDX_DIV_HI = 8'h95;
  localparam logic [7:0] UFC_IDX_CTRL0 = 8'h96;
  localparam logic [7:0] UFC_IDX_CTRL1 = 8'h97;
  localparam logic [7:0] UFC_IDX_RTS = 8'h98;
  localparam logic [7:0] UFC_IDX_TRIG = 8'h99;
  localparam logic [7:0] UFC_IDX_TOUT_BASE = 8'h9a;
  localparam logic [7:0] UFC_IDX_TOUT_SCALE = 8'h9b;
  localparam logic [7:0] UFC_IDX_COUNT = 8'h9c;
  localparam logic [7:0] UFC_IDX_STATUS = 8'h9d;
  localparam logic [7:0] UFC_IDX_NONE = 8'h00;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [7:0] UFC_RST_DIV_LO = 8'hff;
  localparam logic [7:0] UFC_RST_DIV_HI = 8'h0f;
  localparam logic [7:0] UFC_RST_CTRL0 = 8'h0f;
  localparam logic [7:0] UFC_RST_CTRL1 = 8'h0e;
  localparam logic [7:0] UFC_RST_RTS = 8'ha5;
  localparam logic [7:0] UFC_RST_TRIG = 8'h44;
  localparam logic [7:0] UFC_RST_TOUT_BASE = 8'h0f;
  localparam logic [1:0] UFC_RST_TOUT_SCALE = 2'h0;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int UFC_DIV_EN = 7;
  localparam int UFC_C0_RX_DMA = 4;
  localparam int UFC_C0_TX_DMA = 5;
  localparam int UFC_C0_RX_INT = 6;
  localparam int UFC_C0_TX_INT = 7;
  localparam int UFC_C1_CTS_INV = 0;
  localparam int UFC_C1_CTS_EN = 1;
  localparam int UFC_C1_PAR_EN = 2;
  localparam int UFC_C1_PAR_ODD = 3;
  localparam int UFC_C1_STOP_LO = 4;
  localparam int UFC_C1_STOP_HI = 5;
  localparam int UFC_C1_LINE_INV = 6;
  localparam int UFC_C1_LOOP = 7;
  localparam int UFC_RTS_POL = 4;
  localparam int UFC_RTS_MAN_VAL = 5;
  localparam int UFC_RTS_MAN_EN = 6;
  localparam int UFC_RTS_EN = 7;
  localparam int UFC_STS_IRQ = 3;
  localparam int UFC_STS_CLR_RX = 6;
  localparam int UFC_STS_CLR_TX = 7;

  // ****************************************************************
  // Queue shape.
  // ****************************************************************
  localparam int UFC_DATA_W = 8;
  localparam logic [2:0] UFC_DEPTH = 3'h4;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
  } ufc_tx_state_e;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } ufc_rx_state_e;

endpackage : ufc_pkg

// File: rtl/ufc_queue.sv
module ufc_queue
  import ufc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clr,
  input wire logic push,
  input wire logic [UFC_DATA_W-1:0] din,
  input wire logic pop,
  output logic [UFC_DATA_W-1:0] dout,
  output logic [2:0] count
);

  // ****************************************************************
  // Four-entry queue; storage has no reset, head comes from a register.
  // ****************************************************************
  logic [UFC_DATA_W-1:0] mem [0:3];
  logic [1:0] wr_ptr_reg;
  logic [1:0] rd_ptr_reg;
  logic [2:0] count_reg;
  logic [UFC_DATA_W-1:0] dout_reg;
  logic do_push;
  logic do_pop;

  assign do_push = push && (count_reg != UFC_DEPTH);
  assign do_pop = pop && (count_reg != 3'h0);
  assign dout = dout_reg;
  assign count = count_reg;

  always_ff @(posedge ref_clk)
  begin
    if (ce && do_push && !clr)
    begin
      mem[wr_ptr_reg] <= din;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (ce)
    begin
      dout_reg <= mem[rd_ptr_reg];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_reg <= 2'h0;
      rd_ptr_reg <= 2'h0;
      count_reg <= 3'h0;
    end
    else if (ce)
    begin
      if (clr)
      begin
        wr_ptr_reg <= 2'h0;
        rd_ptr_reg <= 2'h0;
        count_reg <= 3'h0;
      end
      else
      begin
        if (do_push)
        begin
          wr_ptr_reg <= wr_ptr_reg + 2'h1;
        end
        if (do_pop)
        begin
          rd_ptr_reg <= rd_ptr_reg + 2'h1;
        end
        if (do_push && !do_pop)
        begin
          count_reg <= count_reg + 3'h1;
        end
        else if (do_pop && !do_push)
        begin
          count_reg <= count_reg - 3'h1;
        end
      end
    end
  end

endmodule : ufc_queue

// File: test/ufc_uart_assertions.sv
module ufc_uart_checker
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic tx_pin,
  input wire logic rx_idle_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic tk;
  assign tk = ce && hsel && htrans[1] && hready;
  a_resp_okay: assert property (!hresp)
    else $error("bus response not okay");
  a_read_wait: assert property
    (tk && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property
    (tk && hwrite |=> hreadyout)
    else $error("write stalled");
  a_rdata_upper: assert property
    (hreadyout |-> !hrdata[31:8])
    else $error("read data upper bits set");
  a_rdata_hold: assert property
    (!$stable(hrdata) |-> !$past(hreadyout))
    else $error("read data changed outside a read");
  a_idle_pulse: assert property
    (rx_idle_done |=> !rx_idle_done)
    else $error("idle pulse too long");
  a_line_idle: assert property ($fell(rst) |-> tx_pin)
    else $error("line not idle after reset");
  a_low_bit_width: assert property
    ($fell(tx_pin) |-> !tx_pin [*4])
    else $error("low bit shorter than four cycles");
  c_read: cover property (tk && !hwrite);
  c_start: cover property ($fell(tx_pin));
  c_idle: cover property (rx_idle_done);
endmodule : ufc_uart_checker

// File: test/ufc_remote.sv
module ufc_remote
#(
  parameter int BT = 16
)
(
  input wire logic ref_clk,
  input wire logic tx_pin,
  input wire logic rts_pin,
  input wire logic rts_act,
  input wire logic par_en,
  output logic rx_pin,
  output logic [7:0] got,
  output int got_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rx_pin = 1'b1;
  initial got_cnt = 0;
  task automatic send(input logic [7:0] d);
    logic [10:0] f;
    while (rts_pin === rts_act) @(posedge ref_clk);
    f = par_en ? {1'b1, ^d, d, 1'b0} : {2'b11, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      rx_pin <= f[i];
      repeat (BT) @(posedge ref_clk);
    end
  endtask : send
  always
  begin
    @(negedge tx_pin);
    repeat (BT / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BT) @(posedge ref_clk);
      got[i] = tx_pin;
    end
    repeat (BT) @(posedge ref_clk);
    got_cnt++;
  end
endmodule : ufc_remote

// File: test/uart_with_flow_control_bench.sv
module uart_with_flow_control_bench
  import ufc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, hsel, hwrite, cts_pin, rts_act, par_en, hreadyout;
  logic hresp, rx_pin, tx_pin, rts_pin, irq, rx_dma_req, tx_dma_req;
  logic rx_idle_done;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd_v;
  logic [7:0] got, x, b [4];
  logic [7:0] ri [11] = '{UFC_IDX_DIV_LO, UFC_IDX_DIV_HI, UFC_IDX_CTRL0,
    UFC_IDX_CTRL1, UFC_IDX_RTS, UFC_IDX_TRIG, UFC_IDX_TOUT_BASE,
    UFC_IDX_TOUT_SCALE, UFC_IDX_COUNT, UFC_IDX_STATUS, UFC_IDX_NONE};
  logic [7:0] rv [11] = '{UFC_RST_DIV_LO, UFC_RST_DIV_HI, UFC_RST_CTRL0,
    UFC_RST_CTRL1, UFC_RST_RTS, UFC_RST_TRIG, UFC_RST_TOUT_BASE,
    {6'h0, UFC_RST_TOUT_SCALE}, 8'h00, 8'h00, 8'h00};
  int got_cnt, fail_count, check_count, n;
  ufc_uart ufc_uart_i (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_pin(rx_pin),
    .cts_pin(cts_pin), .tx_pin(tx_pin), .rts_pin(rts_pin), .irq(irq),
    .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req),
    .rx_idle_done(rx_idle_done));
  ufc_remote ufc_remote_i (.ref_clk(ref_clk), .tx_pin(tx_pin),
    .rts_pin(rts_pin), .rts_act(rts_act), .par_en(par_en),
    .rx_pin(rx_pin), .got(got), .got_cnt(got_cnt));
  function automatic logic [31:0] cnt(input logic [3:0] r,
    input logic [3:0] t);
    return {24'h0, t, r};
  endfunction : cnt
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic chk(input string m, input logic [31:0] e,
    input logic [31:0] s);
    check_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", m, e, s);
    end
  endtask : chk
  task automatic wait_rdy();
    logic r;
    r = 1'b0;
    while (!r)
    begin
      @(negedge ref_clk);
      r = hreadyout;
      rd_v = hrdata;
      @(posedge ref_clk);
    end
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, a, 2'h0};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
  endtask : bus
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    close_out();
  end
  initial
  begin
    {rst, hsel, hwrite, cts_pin, rts_act, par_en} = 6'b10_0000;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    fail_count = 0;
    check_count = 0;
    void'($urandom(32'ha358_55f9));
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("rts idle", 1, rts_pin);
    for (int i = 0; i < 11; i++)
    begin
      bus(0, ri[i], 8'h0);
      chk("reset value", rv[i], rd_v);
    end
    for (int i = 0; i < 11; i++)
    begin
      x = 8'($urandom());
      if (ri[i] == UFC_IDX_CTRL0)
        x[3] = 1'b1;
      b[0] = i > 7 ? 8'h00 : (i == 7 ? x & 8'h03 : x);
      bus(1, ri[i], x);
      bus(0, ri[i], 8'h0);
      chk("write back", b[0], rd_v);
      bus(1, ri[i], rv[i]);
    end
    repeat (200) @(posedge ref_clk);
    $display("test registers done");
    cts_pin <= 1'b1;
    bus(1, UFC_IDX_CTRL1, 8'h02);
    bus(1, UFC_IDX_CTRL0, 8'h2f);
    for (int i = 0; i < 5; i++)
    begin
      x = 8'($urandom());
      if (i < 4)
        b[i] = x;
      bus(1, UFC_IDX_DATA0 + 8'(i % 4), x);
    end
    bus(0, UFC_IDX_COUNT, 8'h0);
    chk("tx held count", cnt(0, 4), rd_v);
    bus(0, UFC_IDX_STATUS, 8'h0);
    chk("status", 32'h40, rd_v);
    chk("tx dma full", 0, tx_dma_req);
    chk("tx held line", 1, tx_pin);
    cts_pin <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      n = got_cnt;
      repeat (400) if (got_cnt == n) @(posedge ref_clk);
      chk("tx byte", b[i], got);
    end
    chk("tx dma room", 1, tx_dma_req);
    $display("test transmit done");
    par_en <= 1'b1;
    rts_act <= 1'b1;
    bus(1, UFC_IDX_CTRL1, 8'h04);
    bus(1, UFC_IDX_CTRL0, 8'h5f);
    bus(1, UFC_IDX_RTS, 8'h94);
    bus(1, UFC_IDX_TRIG, 8'h03);
    bus(1, UFC_IDX_TOUT_BASE, 8'h40);
    for (int i = 0; i < 4; i++)
    begin
      b[i] = 8'($urandom());
      ufc_remote_i.send(b[i]);
      chk("rts level", i == 3, rts_pin);
      chk("rx irq", i >= 2, irq);
      chk("rx dma", 1, rx_dma_req);
    end
    n = 0;
    for (int i = 0; i < 300 && n == 0; i++)
    begin
      @(negedge ref_clk);
      n = int'(rx_idle_done === 1'b1);
    end
    @(posedge ref_clk);
    chk("idle pulse", 1, n);
    for (int i = 0; i < 4; i++)
    begin
      bus(0, UFC_IDX_DATA0 + 8'(i), 8'h0);
      chk("rx byte", b[i], rd_v);
    end
    bus(0, UFC_IDX_STATUS, 8'h0);
    chk("rx status", 0, rd_v);
    chk("rts drop", 0, rts_pin);
    $display("test receive done");
    bus(1, UFC_IDX_CTRL1, 8'h80);
    x = 8'($urandom());
    bus(1, UFC_IDX_DATA1, x);
    rd_v = 0;
    for (int i = 0; i < 100 && rd_v[3:0] == 0; i++)
      bus(0, UFC_IDX_COUNT, 8'h0);
    bus(0, UFC_IDX_DATA2, 8'h0);
    chk("loop byte", x, rd_v);
    $display("test loopback done");
    close_out();
  end
endmodule : uart_with_flow_control_bench
bind ufc_uart ufc_uart_checker ufc_uart_checker_i (.ref_clk(ref_clk),
  .rst(rst), .ce(ce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .tx_pin(tx_pin), .rx_idle_done(rx_idle_done));
